// ===== common/vsg_cfg.svh
// Timing, geometry and register map constants for the video sync generator.
// Assumes the counters advance on line-locked clock ticks (about 70 ns each).
//
// Summary of operation
// - System pins decode 00 NTSC, 01 SECAM, 10 PAL-M, 11 PAL; timing follows.
// - Line holds 910 ticks for NTSC and PAL-M, 908 for PAL and SECAM.
// - Genlock pin high stops the clock-matching loop counter; low means free run.
// - Horizontal, vertical and line-alternate resets act on falling edges only.
// - Resets are sampled on the internal clock; reference must be clock locked.
// - First horizontal edge resets; later edges ignored unless over two ticks off.
// - Horizontal reset loads the line counter 90 ticks ahead of the edge.
// - Vertical reset realigns composite sync to the reference sync phase.
// - Vertical edge past the mid-line boundary shifts the reset by one field, to the field two start.
// - Line-alternate reset sets polarity against the mid-line boundary like vertical.
// - Internal mode keeps a fixed colour-framing phase between field and subcarrier.
// - Line-alternate output toggles at half line rate in every system.
// - Test input idles low for normal operation; its function is for measurement.
// - In SECAM the shared burst pin carries colour blanking instead of burst.
// - Double line rate output runs at exactly twice the line rate output.
// - NTSC internal subcarrier comes from the clock; otherwise from the 4fsc input.
`ifndef VSG_CFG_SVH
`define VSG_CFG_SVH

// Line and frame geometry in ticks and lines
`define VSG_HTOT_525    10'h38E
`define VSG_HTOT_625    10'h38C
`define VSG_LINES_525   11'h20D
`define VSG_LINES_625   11'h271
`define VSG_CF_LAST_525 2'h1
`define VSG_CF_LAST_625 2'h3

// Horizontal reset load phase and jitter window in ticks
`define VSG_HR_LOAD     10'h05A
`define VSG_HR_JITTER   10'h002

// Pulse widths and positions in ticks
`define VSG_HSYNC       10'h043
`define VSG_EQ          10'h021
`define VSG_SERR        10'h043
`define VSG_HDRV        10'h050
`define VSG_HBLK        10'h09E
`define VSG_BF_START    10'h04C
`define VSG_BF_END      10'h070

// Vertical interval boundaries in half lines from the field start
`define VSG_VEQ1_END    11'h006
`define VSG_VBRD_END    11'h00C
`define VSG_VEQ2_END    11'h012
`define VSG_VD_END      11'h012
`define VSG_VBLK_END    11'h028

// Register map, byte addresses
`define VSG_ADDR_CTRL   12'h000
`define VSG_ADDR_STATUS 12'h004
`define VSG_ADDR_PLLREF 12'h008
`define VSG_CTRL_OVR    0
`define VSG_CTRL_SYS_LO 1
`define VSG_CTRL_SYS_HI 2
`define VSG_CTRL_RST    3'h0

`endif

// ===== common/vsg_pkg.sv
// Types shared by the video sync generator modules.
// Assumes the constants header is included by the design files.
package vsg_pkg;

  // Colour system, coded as the two select pins
  typedef enum logic [1:0] {
    VSG_NTSC  = 2'b00,
    VSG_SECAM = 2'b01,
    VSG_PALM  = 2'b10,
    VSG_PAL   = 2'b11
  } vsg_system_t;

  // Registered video outputs, low-active ones marked _n
  typedef struct packed {
    logic sync_n;
    logic odd_field;
    logic first_field;
    logic blank_n;
    logic lalt;
    logic hdrv_n;
    logic vdrv_n;
    logic fh;
    logic f2h;
    logic subcarrier;
    logic bf_cb;
  } vsg_video_t;

  // APB answer held in flops
  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } vsg_apb_rsp_t;

endpackage

// ===== rtl/vsg_edge.sv
// Edge detector for a level that is already synchronous to the clock.
// Assumes the level stays stable for at least one clock after each change.
`timescale 1ns/1ns
module vsg_edge #(
  parameter bit FALLING = 1'b1
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_level,
  output logic      o_pulse
);

  logic prev_reg;
  logic prev_next;

  // Previous level; reset to the idle level so no false edge follows reset
  always_comb
  begin
    prev_next = i_level;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      prev_reg <= FALLING;
    else
      prev_reg <= prev_next;
  end

  // One-cycle pulse on the chosen edge
  assign o_pulse = FALLING ? (prev_reg & ~i_level) : (~prev_reg & i_level);

endmodule

// ===== rtl/vsg_div4.sv
// Divide-by-four of a tick stream, used to form the subcarrier.
// Assumes ticks are one-cycle pulses; clear resynchronises the phase.
`timescale 1ns/1ns
module vsg_div4 (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_clear,
  input  wire logic i_tick,
  output logic      o_out
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;

  // Fixed start phase after clear keeps subcarrier tied to the counters
  always_comb
  begin
    cnt_next = cnt_reg;
    if (i_clear)
      cnt_next = 2'h0;
    else if (i_tick)
      cnt_next = cnt_reg + 2'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      cnt_reg <= 2'h0;
    else
      cnt_reg <= cnt_next;
  end

  assign o_out = cnt_reg[1];

endmodule

// ===== rtl/vsg_top.sv
// Video sync generator: line and field counters, genlock resets, APB registers.
// Assumes all pins are synchronous to i_clk and the line clock is below half of it.
`timescale 1ns/1ns
`include "vsg_cfg.svh"
module vsg_top #(
  parameter int HW = 10,
  parameter int VW = 11
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_line_locked_clock_in,
  input  wire logic        i_quad_subcarrier_in,
  input  wire logic        i_genlock_select,
  input  wire logic        i_system_select_hi,
  input  wire logic        i_system_select_lo,
  input  wire logic        i_horizontal_reset_in,
  input  wire logic        i_vertical_reset_in,
  input  wire logic        i_line_alternate_reset_in,
  input  wire logic        i_test_in,
  output logic             o_composite_sync_out_n,
  output logic             o_odd_even_field_out,
  output logic             o_first_field_out,
  output logic             o_composite_blanking_out_n,
  output logic             o_line_alternate_out,
  output logic             o_horizontal_drive_out_n,
  output logic             o_vertical_drive_out_n,
  output logic             o_line_rate_out,
  output logic             o_double_line_rate_out,
  output logic             o_subcarrier_out,
  output logic             o_burst_flag_or_colour_blank_out
);

  logic              clk_tick;
  logic              fsc_tick;
  logic              hr_edge;
  logic              vr_edge;
  logic              lr_edge;
  logic              sc_raw;
  logic              sc_clear;
  logic              sc_tick;

  logic [HW-1:0]     h_reg;
  logic [HW-1:0]     h_next;
  logic [VW-1:0]     hl_reg;
  logic [VW-1:0]     hl_next;
  logic [1:0]        frame_reg;
  logic [1:0]        frame_next;
  logic              lalt_reg;
  logic              lalt_next;
  logic              locked_reg;
  logic              locked_next;
  logic [HW-1:0]     pll_reg;
  logic [HW-1:0]     pll_next;
  logic [2:0]        ctrl_reg;
  logic [2:0]        ctrl_next;

  vsg_pkg::vsg_video_t   vid_reg;
  vsg_pkg::vsg_video_t   vid_next;
  vsg_pkg::vsg_apb_rsp_t rsp_reg;
  vsg_pkg::vsg_apb_rsp_t rsp_next;
  vsg_pkg::vsg_system_t  sys;

  logic              is525;
  logic [HW-1:0]     htot;
  logic [HW-1:0]     half;
  logic [VW-1:0]     lines;
  logic [VW-1:0]     hltot;
  logic [1:0]        cf_last;
  logic [HW-1:0]     hr_dev;
  logic              hr_in_win;
  logic              pix_tick;
  logic [VW-1:0]     rv;
  logic [HW-1:0]     hp;
  logic              odd_field;
  logic              colour_blank;
  logic              burst;

  // Edge detectors: line clock and 4fsc rising, the three resets falling
  vsg_edge #(.FALLING(1'b0)) u_clk_edge (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_line_locked_clock_in),
    .o_pulse   (clk_tick)
  );

  vsg_edge #(.FALLING(1'b0)) u_fsc_edge (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_quad_subcarrier_in),
    .o_pulse   (fsc_tick)
  );

  vsg_edge #(.FALLING(1'b1)) u_hr_edge (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_horizontal_reset_in),
    .o_pulse   (hr_edge)
  );

  vsg_edge #(.FALLING(1'b1)) u_vr_edge (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_vertical_reset_in),
    .o_pulse   (vr_edge)
  );

  vsg_edge #(.FALLING(1'b1)) u_lr_edge (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_line_alternate_reset_in),
    .o_pulse   (lr_edge)
  );

  // Subcarrier source: clock ticks only for internal NTSC
  assign sc_tick  = (sys == vsg_pkg::VSG_NTSC && !i_genlock_select) ? clk_tick : fsc_tick;
  // Clearing at frame start fixes the colour-framing phase after power-up
  assign sc_clear = pix_tick && (h_reg == htot - 10'h001) && (hl_reg == hltot - 11'h001)
                    && (frame_reg == cf_last) && !i_genlock_select;

  vsg_div4 u_sc_div (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (sc_clear),
    .i_tick    (sc_tick),
    .o_out     (sc_raw)
  );

  // System decode and geometry; the register override wins over the pins
  always_comb
  begin
    if (ctrl_reg[`VSG_CTRL_OVR])
      sys = vsg_pkg::vsg_system_t'(ctrl_reg[`VSG_CTRL_SYS_HI:`VSG_CTRL_SYS_LO]);
    else
      sys = vsg_pkg::vsg_system_t'({i_system_select_hi, i_system_select_lo});
    is525   = (sys == vsg_pkg::VSG_NTSC) || (sys == vsg_pkg::VSG_PALM);
    htot    = is525 ? `VSG_HTOT_525 : `VSG_HTOT_625;
    half    = {1'b0, htot[HW-1:1]};
    lines   = is525 ? `VSG_LINES_525 : `VSG_LINES_625;
    hltot   = {lines[VW-2:0], 1'b0};
    cf_last = is525 ? `VSG_CF_LAST_525 : `VSG_CF_LAST_625;
    // Test pin steps the counters every clock; it idles low when unused
    pix_tick = i_test_in ? 1'b1 : clk_tick;
  end

  // Distance of the current count from the expected reset phase
  always_comb
  begin
    if (h_reg >= `VSG_HR_LOAD)
      hr_dev = h_reg - `VSG_HR_LOAD;
    else
      hr_dev = h_reg + htot - `VSG_HR_LOAD;
    hr_in_win = (hr_dev <= `VSG_HR_JITTER) || (hr_dev >= htot - `VSG_HR_JITTER);
  end

  // Free-running counters, then genlock resets; resets win over the step
  always_comb
  begin
    h_next      = h_reg;
    hl_next     = hl_reg;
    frame_next  = frame_reg;
    lalt_next   = lalt_reg;
    locked_next = locked_reg;
    pll_next    = pll_reg;
    if (pix_tick)
    begin
      if (h_reg >= htot - 10'h001)
      begin
        h_next    = '0;
        lalt_next = ~lalt_reg;
      end
      else
        h_next = h_reg + 10'h001;
      if ((h_reg == half - 10'h001) || (h_reg >= htot - 10'h001))
      begin
        if (hl_reg >= hltot - 11'h001)
        begin
          hl_next    = '0;
          frame_next = (frame_reg >= cf_last) ? 2'h0 : frame_reg + 2'h1;
        end
        else
          hl_next = hl_reg + 11'h001;
      end
      // Clock-matching reference stands still in genlock
      if (!i_genlock_select)
        pll_next = (pll_reg >= htot - 10'h001) ? '0 : pll_reg + 10'h001;
    end
    // First edge always loads; later ones only when outside the jitter window
    if (hr_edge && (!locked_reg || !hr_in_win))
    begin
      h_next      = `VSG_HR_LOAD;
      hl_next     = {hl_next[VW-1:1], 1'b0};
      locked_next = 1'b1;
    end
    // Mid-line boundary picks field one or field two start
    if (vr_edge)
      hl_next = (h_reg < half) ? '0 : lines;
    if (lr_edge)
      lalt_next = (h_reg < half);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      h_reg      <= '0;
      hl_reg     <= '0;
      frame_reg  <= 2'h0;
      lalt_reg   <= 1'b0;
      locked_reg <= 1'b0;
      pll_reg    <= '0;
    end
    else
    begin
      h_reg      <= h_next;
      hl_reg     <= hl_next;
      frame_reg  <= frame_next;
      lalt_reg   <= lalt_next;
      locked_reg <= locked_next;
      pll_reg    <= pll_next;
    end
  end

  // Output decode from counter phase; everything is re-registered
  always_comb
  begin
    odd_field = (hl_reg < lines);
    rv        = odd_field ? hl_reg : hl_reg - lines;
    hp        = (h_reg >= half) ? h_reg - half : h_reg;
    vid_next  = vid_reg;
    if ((rv < `VSG_VEQ1_END) || ((rv >= `VSG_VBRD_END) && (rv < `VSG_VEQ2_END)))
      vid_next.sync_n = ~(hp < `VSG_EQ);
    else if (rv < `VSG_VBRD_END)
      vid_next.sync_n = ~(hp < half - `VSG_SERR);
    else
      vid_next.sync_n = ~(h_reg < `VSG_HSYNC);
    vid_next.blank_n     = ~((h_reg < `VSG_HBLK) || (rv < `VSG_VBLK_END));
    vid_next.hdrv_n      = ~(h_reg < `VSG_HDRV);
    vid_next.vdrv_n      = ~(rv < `VSG_VD_END);
    vid_next.odd_field   = odd_field;
    vid_next.first_field = odd_field && (frame_reg == 2'h0);
    vid_next.lalt        = lalt_reg;
    vid_next.fh          = (h_reg < half);
    vid_next.f2h         = (hp < {1'b0, half[HW-1:1]});
    vid_next.subcarrier  = sc_raw;
    colour_blank = ~vid_next.blank_n;
    burst = (h_reg >= `VSG_BF_START) && (h_reg < `VSG_BF_END) && (rv >= `VSG_VD_END);
    vid_next.bf_cb = (sys == vsg_pkg::VSG_SECAM) ? colour_blank : burst;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      vid_reg <= '{sync_n: 1'b1, blank_n: 1'b1, hdrv_n: 1'b1, vdrv_n: 1'b1, default: 1'b0};
    else
      vid_reg <= vid_next;
  end

  assign o_composite_sync_out_n           = vid_reg.sync_n;
  assign o_odd_even_field_out             = vid_reg.odd_field;
  assign o_first_field_out                = vid_reg.first_field;
  assign o_composite_blanking_out_n       = vid_reg.blank_n;
  assign o_line_alternate_out             = vid_reg.lalt;
  assign o_horizontal_drive_out_n         = vid_reg.hdrv_n;
  assign o_vertical_drive_out_n           = vid_reg.vdrv_n;
  assign o_line_rate_out                  = vid_reg.fh;
  assign o_double_line_rate_out           = vid_reg.f2h;
  assign o_subcarrier_out                 = vid_reg.subcarrier;
  assign o_burst_flag_or_colour_blank_out = vid_reg.bf_cb;

  // APB slave: answer is formed in setup, so access always ends in one cycle
  always_comb
  begin
    ctrl_next = ctrl_reg;
    rsp_next  = '0;
    if (i_psel && !i_penable)
    begin
      rsp_next.ready = 1'b1;
      case (i_paddr)
        `VSG_ADDR_CTRL:   rsp_next.rdata = {29'h0, ctrl_reg};
        `VSG_ADDR_STATUS: rsp_next.rdata = {6'h0, i_genlock_select, locked_reg, odd_field,
                                            sys, hl_reg, h_reg};
        `VSG_ADDR_PLLREF: rsp_next.rdata = {22'h0, pll_reg};
        default:          rsp_next.slverr = 1'b1;
      endcase
      // Read-only registers refuse writes as well
      if (i_pwrite && (i_paddr != `VSG_ADDR_CTRL))
        rsp_next.slverr = 1'b1;
    end
    if (i_psel && i_penable && rsp_reg.ready && i_pwrite && (i_paddr == `VSG_ADDR_CTRL))
      ctrl_next = i_pwdata[2:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ctrl_reg <= `VSG_CTRL_RST;
      rsp_reg  <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      rsp_reg  <= rsp_next;
    end
  end

  assign o_prdata  = rsp_reg.rdata;
  assign o_pready  = rsp_reg.ready;
  assign o_pslverr = rsp_reg.slverr;

endmodule

// ===== tb/vsg_ref_src.sv
// Reference sync source: line clock, 4fsc clock and genlock reset pulses.
// Assumes the bench pulses one bit of i_fire for one clock per reset wanted.
`timescale 1ns/1ns
module vsg_ref_src (
  input  wire logic       i_clk,
  input  wire logic [2:0] i_fire,
  output logic            o_lclk,
  output logic            o_fsc,
  output logic [2:0]      o_rst_n
);
  logic [1:0] ph_reg = 2'h0;
  logic [5:0] low_reg [3] = '{default: 6'h00};

  // Line clock at a quarter of i_clk, locked to it so reset edges keep one phase
  always_ff @(posedge i_clk)
  begin
    ph_reg <= ph_reg + 2'h1;
  end
  assign o_lclk = ph_reg[1];
  assign o_fsc  = ph_reg[0];

  // Each reset line idles high and falls for 40 clocks, well over the minimum
  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < 3; k++)
    begin
      if (i_fire[k])
        low_reg[k] <= 6'h28;
      else if (low_reg[k] != 6'h00)
        low_reg[k] <= low_reg[k] - 6'h01;
    end
  end
  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      o_rst_n[k] = (low_reg[k] == 6'h00);
    end
  end
endmodule

// ===== tb/vsg_chk.sv
// Checker for the sync generator: APB answers and line timing at the pins.
// Assumes one tick per rising edge of the line clock pin.
`timescale 1ns/1ns
module vsg_chk (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_line_locked_clock_in,
  input wire logic        i_system_select_hi,
  input wire logic        i_system_select_lo,
  input wire logic        i_horizontal_reset_in,
  input wire logic        i_line_alternate_reset_in,
  input wire logic        i_test_in,
  input wire logic        o_horizontal_drive_out_n,
  input wire logic        o_composite_blanking_out_n,
  input wire logic        o_line_alternate_out,
  input wire logic        o_line_rate_out,
  input wire logic        o_double_line_rate_out,
  input wire logic        o_burst_flag_or_colour_blank_out
);
  logic [10:0] tick_reg;
  logic [10:0] tick_next;
  logic [3:0]  prev_reg;
  logic [3:0]  prev_next;
  logic [1:0]  skip_reg;
  logic [1:0]  skip_next;
  logic        ovr_reg;
  logic        ovr_next;
  logic        rise_fh;
  logic        tick;

  // Ticks per line; system and horizontal resets, pin moves and test mode void two line checks; an override voids all until reset
  always_comb
  begin
    prev_next = {i_line_locked_clock_in, i_system_select_hi, i_system_select_lo,
                 o_line_rate_out};
    tick = i_line_locked_clock_in && !prev_reg[3];
    rise_fh = o_line_rate_out && !prev_reg[0];
    tick_next = rise_fh ? 11'(tick) : tick_reg + 11'(tick);
    ovr_next = ovr_reg || (i_psel && i_penable && i_pwrite && i_paddr == 12'h000);
    skip_next = (rise_fh && skip_reg != 2'h0) ? skip_reg - 2'h1 : skip_reg;
    if (i_sys_rst || !i_horizontal_reset_in || prev_next[2:1] != prev_reg[2:1] || i_test_in)
      skip_next = 2'h2;
  end
  always_ff @(posedge i_clk)
  begin
    prev_reg <= prev_next;
    tick_reg <= tick_next;
    skip_reg <= skip_next;
    ovr_reg  <= ovr_next && !i_sys_rst;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_ready_zero_wait: assert property (i_psel && !i_penable |=> o_pready) // APB timing
    else $error("pready not in first access cycle");
  a_err_with_ready: assert property (o_pslverr |-> o_pready) // APB answer
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0) // APB answer
    else $error("read data outside access");
  a_refused_err: assert property (i_psel && i_penable && o_pready &&
    (!(i_paddr inside {12'h000, 12'h004, 12'h008}) || (i_pwrite && i_paddr != 12'h000))
    |-> o_pslverr) // APB refusal
    else $error("bad access not refused");
  a_double_rate: assert property ($rose(o_line_rate_out) |-> $rose(o_double_line_rate_out))
    else $error("double rate not aligned");
  a_lalt_at_line: assert property (disable iff (i_sys_rst || !i_line_alternate_reset_in)
    $changed(o_line_alternate_out) |-> $rose(o_line_rate_out))
    else $error("line alternate moved mid line");
  a_drive_at_line: assert property ($rose(o_line_rate_out) |->
    !o_horizontal_drive_out_n && !o_composite_blanking_out_n)
    else $error("drive or blank idle at line start");
  a_line_ticks: assert property ($rose(o_line_rate_out) && skip_reg == 2'h0 && !ovr_reg
    |-> tick_reg == (i_system_select_lo ? 11'h38C : 11'h38E))
    else $error("line length wrong");
  a_burst_sys: assert property ($rose(o_line_rate_out) && skip_reg == 2'h0 && !ovr_reg
    |-> o_burst_flag_or_colour_blank_out == (!i_system_select_hi && i_system_select_lo))
    else $error("burst pin wrong at line start");

  c_line: cover property ($rose(o_line_rate_out) && skip_reg == 2'h0);
  c_refused: cover property (o_pslverr);
  c_hreset: cover property ($fell(i_horizontal_reset_in));
endmodule

bind vsg_top vsg_chk chk_u (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .o_prdata, .o_pready, .o_pslverr, .i_line_locked_clock_in, .i_system_select_hi,
  .i_system_select_lo, .i_horizontal_reset_in, .i_line_alternate_reset_in, .i_test_in,
  .o_horizontal_drive_out_n, .o_composite_blanking_out_n, .o_line_alternate_out,
  .o_line_rate_out, .o_double_line_rate_out, .o_burst_flag_or_colour_blank_out);

// ===== tb/video_camera_sync_generator_test.sv
// Bench for the sync generator: systems, register override, genlock resets.
// Assumes the reference source ticks the line clock every fourth i_clk.
`timescale 1ns/1ns
module video_camera_sync_generator_test;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic        gl;
  logic        shi;
  logic        slo;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] pll;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        lclk;
  logic        fsc;
  logic        hd_n;
  logic        vd_n;
  logic        odd;
  logic        fh;
  logic        fh_d;
  logic        lalt;
  logic        la;
  logic        bf;
  logic        tst;
  logic        sc;
  logic        sync_n;
  logic        ff;
  logic [2:0]  fire;
  logic [2:0]  rst_n;
  logic [7:0]  lf;
  int          n_fail;
  int          total_checks;
  int          cyc = 0;
  int          f;
  int          t;
  int          a;
  int          tone;
  int          htot;
  int          ls_q[$];

  vsg_ref_src ref_u (.i_clk(clk), .i_fire(fire), .o_lclk(lclk), .o_fsc(fsc), .o_rst_n(rst_n));
  vsg_top dut_u (
    .i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_line_locked_clock_in(lclk), .i_quad_subcarrier_in(fsc),
    .i_genlock_select(gl), .i_system_select_hi(shi), .i_system_select_lo(slo),
    .i_horizontal_reset_in(rst_n[0]), .i_vertical_reset_in(rst_n[1]),
    .i_line_alternate_reset_in(rst_n[2]), .i_test_in(tst),
    .o_composite_sync_out_n(sync_n), .o_odd_even_field_out(odd), .o_first_field_out(ff),
    .o_composite_blanking_out_n(), .o_line_alternate_out(lalt),
    .o_horizontal_drive_out_n(hd_n), .o_vertical_drive_out_n(vd_n),
    .o_line_rate_out(fh), .o_double_line_rate_out(), .o_subcarrier_out(sc),
    .o_burst_flag_or_colour_blank_out(bf));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Line starts logged by cycle number; timing figures are differences of these
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (fh === 1'b1 && fh_d === 1'b0)
      ls_q.push_back(cyc);
    fh_d <= fh;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_time(input string nm, input int e, input int g, input int tol);
    total_checks++;
    if (g < e - tol || g > e + tol)
    begin
      n_fail++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic fail_hang(input string nm);
    chk_val(nm, 32'h1, 32'h0);
    tally_and_finish();
  endtask

  task automatic next_ls(output int tm);
    int n;
    n = ls_q.size();
    for (int i = 0; i < 5000 && ls_q.size() == n; i++)
      @(negedge clk);
    if (ls_q.size() == n)
      fail_hang("line start");
    tm = ls_q[$];
  endtask

  // Reset pulse requested at an exact cycle so edges keep the tick phase
  task automatic fire_at(input int tg, input logic [2:0] w);
    for (int i = 0; i < 8000 && cyc < tg; i++)
      @(posedge clk);
    if (cyc != tg)
      fail_hang("fire time");
    fire <= w;
    @(posedge clk);
    fire <= 3'h0;
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (int i = 0; i < 16 && pready !== 1'b1; i++)
      @(posedge clk);
    if (pready !== 1'b1)
      fail_hang("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic sys_reset(input logic [1:0] s);
    @(posedge clk);
    rst <= 1'b1;
    {shi, slo} <= s;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  initial
  begin
    {psel, pen, pwr, gl, shi, slo, tst} = 7'h00;
    paddr  = 12'h000;
    pwdata = 32'h0;
    fire   = 3'h0;
    lf     = 8'h3F;
    rst    = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Every system code: line length, alternate toggle, burst pin, status
    for (int s = 0; s < 4; s++)
    begin
      sys_reset(s[1:0]);
      htot = s[0] ? 908 : 910;
      repeat (2) next_ls(t);
      la = lalt;
      next_ls(tone);
      chk_time("line period", htot * 4, tone - t, 0);
      chk_val("line alternate", {31'h0, ~la}, {31'h0, lalt});
      repeat (160) @(negedge clk);
      chk_val("burst pin", {31'h0, s == 1}, {31'h0, bf});
      chk_val("drive", 32'h0, {31'h0, hd_n});
      chk_val("first field", 32'h1, {31'h0, ff});
      apb(1'b0, 12'h004, 32'h0);
      chk_val("status system", 32'(s), {30'h0, rd[22:21]});
      $display("test system %0d done", s);
    end
    // Register override, then read-only and unmapped places refused
    sys_reset(2'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk_val("ctrl reset", 32'h0, rd);
    lf = lfsr(lf);
    apb(1'b1, 12'h000, {lf, lf, lf, lf[7:3], 3'h7});
    apb(1'b0, 12'h004, 32'h0);
    chk_val("status override", 32'h3, {30'h0, rd[22:21]});
    repeat (2) next_ls(t);
    next_ls(tone);
    chk_time("override period", 908 * 4, tone - t, 0);
    for (int k = 0; k < 3; k++)
    begin
      lf = lfsr(lf);
      apb(k < 2, k < 2 ? 12'h004 << k : {lf, 4'hC}, {lf, 24'h0});
      chk_val("refused", 32'h1, {31'h0, err});
      if (k < 2)
        apb(1'b0, 12'h000, 32'h0);
      chk_val("refused data", k < 2 ? 32'h7 : 32'h0, rd);
    end
    $display("test registers done");
    // Genlock: loop counter frozen, then H, V and alternate resets
    sys_reset(2'h0);
    htot = 910;
    apb(1'b0, 12'h008, 32'h0);
    pll = rd;
    repeat (8) @(posedge clk);
    apb(1'b0, 12'h008, 32'h0);
    chk_val("loop runs", 32'h1, {31'h0, pll !== rd});
    gl <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    pll = rd;
    repeat (50) @(posedge clk);
    apb(1'b0, 12'h008, 32'h0);
    chk_val("loop frozen", pll, rd);
    f = cyc + 2;
    fire_at(f, 3'h1);
    next_ls(t);
    tone = t - f;
    chk_time("reset phase", (htot - 90) * 4, tone, 8);
    fire_at(t + htot * 4 - tone + 4, 3'h1);
    next_ls(a);
    chk_time("jitter kept", t + htot * 4, a, 0);
    fire_at(a + htot * 4 - tone + 20, 3'h1);
    next_ls(t);
    chk_time("jitter reload", a + htot * 4 + 20, t, 0);
    for (int k = 0; k < 2; k++)
    begin
      fire_at(t + 100 + k * 1900, 3'h6);
      repeat (10) @(negedge clk);
      chk_val("alternate reset", {31'h0, k == 0}, {31'h0, lalt});
      chk_val("field after reset", {31'h0, k == 0}, {31'h0, odd});
      chk_val("vertical drive", 32'h0, {31'h0, vd_n});
    end
    $display("test genlock done");
    // Test pin steps every clock, so active lines come quickly
    sys_reset(2'h0);
    {gl, tst} <= 2'b01;
    repeat (12) next_ls(t);
    next_ls(tone);
    chk_time("test period", 910, tone - t, 0);
    la = sc;
    repeat (8) @(negedge clk);
    chk_val("subcarrier", {31'h0, ~la}, {31'h0, sc});
    repeat (22) @(negedge clk);
    chk_val("sync", 32'h0, {31'h0, sync_n});
    repeat (60) @(negedge clk);
    chk_val("burst flag", 32'h1, {31'h0, bf});
    $display("test speed done");
    tally_and_finish();
  end
endmodule
